// file: hw/debug_ctrl_register_bank.sv
// Behaviour
// - One 8-bit status and control register holds control and status bits.
// - A 16-bit breakpoint match register holds the breakpoint compare address.
// - Registers reached only by serial debug commands, no memory-map path.
// - Both registers are readable and writable any time, subject to bit limits.
// - Mode-enable bit write is ignored while active background mode is on.
// - Active, wait/stop, wait/stop failure, data-valid failure are read-only.
// - Clock-select bit is writable at all times, including active mode.
// - Status read and control write commands access status/control register.
// - Enable clear refuses active-mode entry; non-intrusive commands still run.
// - Breakpoint enable clear ignores force/tag and match; no breakpoint request.
// - Force/tag set selects forced, clear selects tagged breakpoints.
//
// Purpose: Status/control and breakpoint match registers of the debug controller
// Assumes: Command decoder supplies one-cycle strobes; status bits come from the core
// Notes: Read-only bits mirror the core status, refreshed every clock
`timescale 1ns/100ps
module debug_ctrl_register_bank #(
  parameter int SC_W = 8,
  parameter int BK_W = 16
)
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic RESET_IN_ACTIVE,
  input wire logic STATUS_RD,
  input wire logic CONTROL_WR,
  input wire logic [7:0] CONTROL_WDATA,
  input wire logic BKPT_RD,
  input wire logic BKPT_WR,
  input wire logic [15:0] BKPT_WDATA,
  input wire dbg_regs_pkg::core_status_t CORE_STATUS,
  input wire logic ENTRY_REQ,
  output logic [7:0] STATUS_RDATA,
  output logic STATUS_RVALID,
  output logic [15:0] BKPT_RDATA,
  output logic BKPT_RVALID,
  output logic MODE_ENABLE,
  output logic CLOCK_SELECT,
  output logic ENTRY_GRANT,
  output dbg_regs_pkg::bkpt_req_t BKPT_REQ
);

  // Field map and masks are fixed, so other widths cannot be served
  if (SC_W != dbg_regs_pkg::SC_WIDTH || BK_W != dbg_regs_pkg::BKPT_WIDTH)
  begin
    $error("Register widths are fixed at 8 and 16 bits");
  end

  // ----------------------------------------
  // Status and control register
  // ----------------------------------------
  logic [7:0] sc_q;
  logic [7:0] sc_d;
  logic [15:0] bkpt_q;
  logic [7:0] wmask;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Mode-enable protected while active; clock select always open
  always_comb
  begin
    wmask = sc_q[dbg_regs_pkg::BIT_ACTIVE] ? dbg_regs_pkg::SC_WRITE_MASK_ACTIVE
                                           : dbg_regs_pkg::SC_WRITE_MASK;
    sc_d = sc_q;
    if (CONTROL_WR)
    begin
      sc_d = merge(sc_q, CONTROL_WDATA, wmask);
    end
    // Status bits always follow the core, so writes cannot reach them
    sc_d[dbg_regs_pkg::BIT_ACTIVE] = CORE_STATUS.active;
    sc_d[dbg_regs_pkg::BIT_WAIT_STOP] = CORE_STATUS.wait_stop;
    sc_d[dbg_regs_pkg::BIT_WAIT_FAIL] = CORE_STATUS.wait_stop_fail;
    sc_d[dbg_regs_pkg::BIT_DATA_FAIL] = CORE_STATUS.data_valid_fail;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      sc_q <= RESET_IN_ACTIVE ? dbg_regs_pkg::SC_RESET_ACTIVE
                              : dbg_regs_pkg::SC_RESET_NORMAL;
    end
    else
    begin
      sc_q <= sc_d;
    end
  end

  // ----------------------------------------
  // Breakpoint match register
  // ----------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      bkpt_q <= dbg_regs_pkg::BKPT_RESET;
    end
    else if (BKPT_WR)
    begin
      bkpt_q <= BKPT_WDATA;
    end
  end

  // ----------------------------------------
  // Read answers, serial path only
  // ----------------------------------------
  // Reads return the value held before any same-cycle write
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      STATUS_RDATA <= 8'h00;
      STATUS_RVALID <= 1'b0;
      BKPT_RDATA <= 16'h0000;
      BKPT_RVALID <= 1'b0;
    end
    else
    begin
      STATUS_RVALID <= STATUS_RD;
      BKPT_RVALID <= BKPT_RD;
      if (STATUS_RD)
      begin
        STATUS_RDATA <= sc_q;
      end
      if (BKPT_RD)
      begin
        BKPT_RDATA <= bkpt_q;
      end
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      MODE_ENABLE <= 1'b0;
      CLOCK_SELECT <= 1'b0;
      ENTRY_GRANT <= 1'b0;
      BKPT_REQ <= '0;
    end
    else
    begin
      MODE_ENABLE <= sc_q[dbg_regs_pkg::BIT_MODE_EN];
      CLOCK_SELECT <= sc_q[dbg_regs_pkg::BIT_CLK_SEL];
      ENTRY_GRANT <= ENTRY_REQ && sc_q[dbg_regs_pkg::BIT_MODE_EN];
      if (!sc_q[dbg_regs_pkg::BIT_BKPT_EN])
      begin
        BKPT_REQ <= '0;
      end
      else
      begin
        BKPT_REQ.addr <= bkpt_q;
        BKPT_REQ.kind <= sc_q[dbg_regs_pkg::BIT_FORCE_TAG] ? dbg_regs_pkg::BKPT_FORCED
                                                          : dbg_regs_pkg::BKPT_TAGGED;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_enable_locked;
    @(posedge CLOCK) disable iff (!RSTN)
    sc_q[dbg_regs_pkg::BIT_ACTIVE] |=>
      sc_q[dbg_regs_pkg::BIT_MODE_EN] == $past(sc_q[dbg_regs_pkg::BIT_MODE_EN]);
  endproperty
  a_enable_locked: assert property (p_enable_locked) else $error("Enable changed while active");

  property p_clksel_write;
    @(posedge CLOCK) disable iff (!RSTN)
    CONTROL_WR |=>
      sc_q[dbg_regs_pkg::BIT_CLK_SEL] == $past(CONTROL_WDATA[dbg_regs_pkg::BIT_CLK_SEL]);
  endproperty
  a_clksel_write: assert property (p_clksel_write) else $error("Clock select write lost");

  property p_status_follow;
    @(posedge CLOCK) disable iff (!RSTN)
    1'b1 |=> sc_q[2:0] == $past({CORE_STATUS.wait_stop, CORE_STATUS.wait_stop_fail,
                                 CORE_STATUS.data_valid_fail});
  endproperty
  a_status_follow: assert property (p_status_follow) else $error("Status bit written");

  property p_active_follow;
    @(posedge CLOCK) disable iff (!RSTN)
    1'b1 |=> sc_q[dbg_regs_pkg::BIT_ACTIVE] == $past(CORE_STATUS.active);
  endproperty
  a_active_follow: assert property (p_active_follow) else $error("Active bit written");

  property p_bkpt_write;
    @(posedge CLOCK) disable iff (!RSTN)
    BKPT_WR ##1 !BKPT_WR ##1 BKPT_RD |=> BKPT_RVALID && BKPT_RDATA == $past(BKPT_WDATA, 3);
  endproperty
  a_bkpt_write: assert property (p_bkpt_write) else $error("Breakpoint readback wrong");

  property p_status_read;
    @(posedge CLOCK) disable iff (!RSTN)
    STATUS_RD |=> STATUS_RVALID && STATUS_RDATA == $past(sc_q);
  endproperty
  a_status_read: assert property (p_status_read) else $error("Status read wrong");

  property p_no_grant;
    @(posedge CLOCK) disable iff (!RSTN)
    !sc_q[dbg_regs_pkg::BIT_MODE_EN] |=> !ENTRY_GRANT;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("Entry granted while disabled");

  property p_no_bkpt;
    @(posedge CLOCK) disable iff (!RSTN)
    !sc_q[dbg_regs_pkg::BIT_BKPT_EN] |=> BKPT_REQ.kind == dbg_regs_pkg::BKPT_OFF;
  endproperty
  a_no_bkpt: assert property (p_no_bkpt) else $error("Breakpoint while disabled");

  property p_forced;
    @(posedge CLOCK) disable iff (!RSTN)
    sc_q[dbg_regs_pkg::BIT_BKPT_EN] && sc_q[dbg_regs_pkg::BIT_FORCE_TAG] |=>
      BKPT_REQ.kind == dbg_regs_pkg::BKPT_FORCED;
  endproperty
  a_forced: assert property (p_forced) else $error("Force select ignored");

  property p_reset_img;
    @(posedge CLOCK)
    !RSTN && !RESET_IN_ACTIVE |=> sc_q == dbg_regs_pkg::SC_RESET_NORMAL;
  endproperty
  a_reset_img: assert property (p_reset_img) else $error("Normal reset image wrong");

endmodule

// file: shared/dbg_regs_pkg.sv
// Purpose: Shared constants and types for the debug register bank
// Assumes: Status/control is 8 bits, breakpoint match is 16 bits
// Notes: Bit positions and reset images are named once here
package dbg_regs_pkg;

  // ----------------------------------------
  // Field positions of debug_status_control
  // ----------------------------------------
  localparam int BIT_MODE_EN = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_BKPT_EN = 5;
  localparam int BIT_FORCE_TAG = 4;
  localparam int BIT_CLK_SEL = 3;
  localparam int BIT_WAIT_STOP = 2;
  localparam int BIT_WAIT_FAIL = 1;
  localparam int BIT_DATA_FAIL = 0;

  localparam int SC_WIDTH = 8;
  localparam int BKPT_WIDTH = 16;

  // ----------------------------------------
  // Reset images
  // ----------------------------------------
  localparam logic [7:0] SC_RESET_NORMAL = 8'h00;
  localparam logic [7:0] SC_RESET_ACTIVE = 8'hC8;
  localparam logic [15:0] BKPT_RESET = 16'h0000;

  // Bits that the control-write command may change outside active mode
  localparam logic [7:0] SC_WRITE_MASK = 8'hB8;
  // Mode-enable bit is dropped from the mask while active
  localparam logic [7:0] SC_WRITE_MASK_ACTIVE = 8'h38;

  typedef enum logic [1:0]
  {
    BKPT_OFF = 2'b00,
    BKPT_TAGGED = 2'b01,
    BKPT_FORCED = 2'b10
  } bkpt_kind_t;

  // Status bits sampled from the core
  typedef struct packed
  {
    logic active;
    logic wait_stop;
    logic wait_stop_fail;
    logic data_valid_fail;
  } core_status_t;

  // Breakpoint request presented to the comparator
  typedef struct packed
  {
    bkpt_kind_t kind;
    logic [15:0] addr;
  } bkpt_req_t;

endpackage

// file: tb/debug_ctrl_register_bank_tb.sv
// Purpose: Self-checking bench for the debug register bank
// Assumes: Inputs change at the falling edge
// Notes: Read results carry the valid flag as their top bit
`timescale 1ns/100ps
module debug_ctrl_register_bank_tb;
  logic clock, rstn, reset_in_active, entry_req;
  logic status_rd, control_wr, bkpt_rd, bkpt_wr, status_rvalid, bkpt_rvalid;
  logic mode_enable, clock_select, entry_grant;
  logic [7:0] control_wdata, status_rdata;
  logic [15:0] bkpt_wdata, bkpt_rdata;
  dbg_regs_pkg::core_status_t core_status;
  dbg_regs_pkg::bkpt_req_t bkpt_req;
  int errors = 0;
  int samples_checked = 0;
  logic [8:0] rs;
  logic [16:0] rb;

  debug_ctrl_register_bank uut (.CLOCK(clock), .RSTN(rstn), .RESET_IN_ACTIVE(reset_in_active),
    .STATUS_RD(status_rd), .CONTROL_WR(control_wr), .CONTROL_WDATA(control_wdata),
    .BKPT_RD(bkpt_rd), .BKPT_WR(bkpt_wr), .BKPT_WDATA(bkpt_wdata), .CORE_STATUS(core_status),
    .ENTRY_REQ(entry_req), .STATUS_RDATA(status_rdata), .STATUS_RVALID(status_rvalid),
    .BKPT_RDATA(bkpt_rdata), .BKPT_RVALID(bkpt_rvalid), .MODE_ENABLE(mode_enable),
    .CLOCK_SELECT(clock_select), .ENTRY_GRANT(entry_grant), .BKPT_REQ(bkpt_req));

  debug_host_model host (.clock(clock), .status_rd(status_rd), .control_wr(control_wr),
    .control_wdata(control_wdata), .bkpt_rd(bkpt_rd), .bkpt_wr(bkpt_wr),
    .bkpt_wdata(bkpt_wdata), .status_rdata(status_rdata), .status_rvalid(status_rvalid),
    .bkpt_rdata(bkpt_rdata), .bkpt_rvalid(bkpt_rvalid));

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic act);
    @(negedge clock);
    rstn = 1'b0;
    reset_in_active = act;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    reset_in_active = 1'b0;
  endtask

  // Write, then let the registered outputs catch up
  task automatic wr_settle(input logic [7:0] d);
    host.write_control(d);
    repeat (2) @(negedge clock);
  endtask

  task automatic t_normal_reset();
    do_reset(1'b0);
    host.read_status(rs);
    check("status", 18'(rs), 18'({1'b1, 8'h00}));
    host.read_bkpt(rb);
    check("bkpt", 18'(rb), 18'({1'b1, 16'h0000}));
  endtask

  task automatic t_write_fields();
    wr_settle(8'hFF);
    host.read_status(rs);
    check("status", 18'(rs), 18'({1'b1, 8'hB8}));
    check("mode_enable", 18'(mode_enable), 18'(1'b1));
    check("clock_select", 18'(clock_select), 18'(1'b1));
    host.write_bkpt(16'hA55A);
    host.read_bkpt(rb);
    check("bkpt", 18'(rb), 18'({1'b1, 16'hA55A}));
    check("bkpt_req", bkpt_req, {dbg_regs_pkg::BKPT_FORCED, 16'hA55A});
    wr_settle(8'hA8);
    check("bkpt_req", bkpt_req, {dbg_regs_pkg::BKPT_TAGGED, 16'hA55A});
    wr_settle(8'h98);
    check("bkpt_req", bkpt_req, 18'h0_0000);
  endtask

  task automatic t_entry();
    entry_req = 1'b1;
    repeat (2) @(negedge clock);
    check("entry_grant", 18'(entry_grant), 18'(1'b1));
    wr_settle(8'h08);
    check("entry_grant", 18'(entry_grant), 18'(1'b0));
    entry_req = 1'b0;
  endtask

  task automatic t_active_lock();
    wr_settle(8'h80);
    core_status = 4'b1111;
    repeat (2) @(negedge clock);
    wr_settle(8'h08);
    host.read_status(rs);
    check("status", 18'(rs), 18'({1'b1, 8'hCF}));
    wr_settle(8'h00);
    host.read_status(rs);
    check("status", 18'(rs), 18'({1'b1, 8'hC7}));
    core_status = 4'b0000;
    repeat (2) @(negedge clock);
    wr_settle(8'h00);
    host.read_status(rs);
    check("status", 18'(rs), 18'({1'b1, 8'h00}));
  endtask

  task automatic t_active_reset();
    core_status = 4'b1000;
    do_reset(1'b1);
    host.read_status(rs);
    check("status", 18'(rs), 18'({1'b1, 8'hC8}));
    check("mode_enable", 18'(mode_enable), 18'(1'b1));
    core_status = 4'b0000;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    rstn = 1'b0;
    reset_in_active = 1'b0;
    entry_req = 1'b0;
    core_status = 4'b0000;
    t_normal_reset();
    t_write_fields();
    t_entry();
    t_active_lock();
    t_active_reset();
    test_done();
  end

  // Whole run is under a hundred cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule

// file: tb/debug_host_model.sv
// Purpose: Behavioural debug host issuing serial register commands
// Assumes: Strobes launched at the falling edge, one cycle long
// Notes: Write data is inverted once the strobe drops, never left valid
`timescale 1ns/100ps
module debug_host_model
(
  input wire logic clock,
  output logic status_rd,
  output logic control_wr,
  output logic [7:0] control_wdata,
  output logic bkpt_rd,
  output logic bkpt_wr,
  output logic [15:0] bkpt_wdata,
  input wire logic [7:0] status_rdata,
  input wire logic status_rvalid,
  input wire logic [15:0] bkpt_rdata,
  input wire logic bkpt_rvalid
);
  initial
  begin
    status_rd = 1'b0;
    control_wr = 1'b0;
    control_wdata = 8'h00;
    bkpt_rd = 1'b0;
    bkpt_wr = 1'b0;
    bkpt_wdata = 16'h0000;
  end

  task automatic write_control(input logic [7:0] d);
    @(negedge clock);
    control_wr = 1'b1;
    control_wdata = d;
    @(negedge clock);
    control_wr = 1'b0;
    control_wdata = ~d;
  endtask

  task automatic read_status(output logic [8:0] r);
    @(negedge clock);
    status_rd = 1'b1;
    @(negedge clock);
    status_rd = 1'b0;
    r = {status_rvalid, status_rdata};
  endtask

  task automatic write_bkpt(input logic [15:0] d);
    @(negedge clock);
    bkpt_wr = 1'b1;
    bkpt_wdata = d;
    @(negedge clock);
    bkpt_wr = 1'b0;
    bkpt_wdata = ~d;
  endtask

  task automatic read_bkpt(output logic [16:0] r);
    @(negedge clock);
    bkpt_rd = 1'b1;
    @(negedge clock);
    bkpt_rd = 1'b0;
    r = {bkpt_rvalid, bkpt_rdata};
  endtask
endmodule
